// *** src/jslm_mapper.sv ***
// Transport-layer mapper: packs channel samples into per-lane octet frames
// for link modes 0 to 3. Expects one sample per present channel on each
// cycle with samp_valid high; line coding follows downstream.
`timescale 1ns/100ps
module jslm_mapper #(
    parameter int NUM_CH = jslm_pkg::CHANS  // Variant: 1, 2 or 4
) (
    // Clock, reset, enable
    input  wire logic                         clk,
    input  wire logic                         reset,
    input  wire logic                         ce,
    // Configuration
    input  wire logic [1:0]                   link_mode_select,
    // Sample stream, one per channel
    input  wire logic                         samp_valid,
    input  wire logic [jslm_pkg::SAMP_W-1:0]  samp [jslm_pkg::CHANS],
    // Lane frames
    output logic                              frame_valid,
    output logic      [jslm_pkg::LANES-1:0]   lane_en,
    output logic      [3:0]                   lane_octets,
    output logic      [jslm_pkg::LANE_W-1:0]  lane_data [jslm_pkg::LANES]
);
    localparam int SW = jslm_pkg::SAMP_W;
    localparam int LW = jslm_pkg::LANE_W;
    localparam int NL = jslm_pkg::LANES;
    localparam int NC = jslm_pkg::CHANS;
    localparam int MS = jslm_pkg::MAX_SAMP;
    localparam logic [jslm_pkg::PAD_W-1:0] PAD = '0;

    // ----------------------------------------------------------------
    // Mode tracking
    // ----------------------------------------------------------------
    logic [1:0] mode_q;
    logic [1:0] mode_d;
    logic       flush;
    logic [3:0] need;
    logic [3:0] octets;
    logic [3:0] lane_cnt;
    logic [NL-1:0] en_mask;

    // A mode change drops any half-gathered frame rather than mixing layouts
    always_comb begin
        flush  = (link_mode_select != mode_q);
        mode_d = link_mode_select;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            mode_q <= jslm_pkg::MODE_9B_WIDE;
        end else if (ce) begin
            mode_q <= mode_d;
        end
    end

    // Frame shape and lane count for the current mode and variant
    always_comb begin
        case (mode_q)
            jslm_pkg::MODE_9B_WIDE: begin
                need     = jslm_pkg::NEED_M0;
                octets   = jslm_pkg::OCT_M0;
                lane_cnt = 4'(2 * NUM_CH);
            end
            jslm_pkg::MODE_9B_PACKED: begin
                need   = jslm_pkg::NEED_M1;
                octets = jslm_pkg::OCT_M1;
                lane_cnt = (NUM_CH == 1) ? jslm_pkg::M1_LANES_1CH :
                           (NUM_CH == 2) ? jslm_pkg::M1_LANES_2CH :
                                           jslm_pkg::M1_LANES_4CH;
            end
            jslm_pkg::MODE_8B_SINGLE: begin
                need     = jslm_pkg::NEED_M2;
                octets   = jslm_pkg::OCT_M2;
                lane_cnt = 4'(NUM_CH);
            end
            default: begin
                need     = jslm_pkg::NEED_M3;
                octets   = jslm_pkg::OCT_M3;
                lane_cnt = 4'(NUM_CH);
            end
        endcase
        en_mask = NL'((9'h001 << lane_cnt) - 9'h001);
    end

    // ----------------------------------------------------------------
    // Per-channel gathering
    // ----------------------------------------------------------------
    logic [SW-1:0] ch_slot [NC][MS];
    logic [NC-1:0] ch_done;

    // Absent channels read as zero so their lane positions carry zeros
    generate
        for (genvar g = 0; g < NC; g++) begin : g_ch
            if (g < NUM_CH) begin : g_on
                jslm_chan_gather #(.SW(SW), .DEPTH(MS)) u_gather (
                    .clk       (clk),
                    .reset     (reset),
                    .ce        (ce),
                    .flush     (flush),
                    .need      (need),
                    .in_valid  (samp_valid),
                    .in_sample (samp[g]),
                    .slots     (ch_slot[g]),
                    .done      (ch_done[g])
                );
            end else begin : g_off
                always_comb begin
                    ch_done[g] = 1'b0;
                    for (int k = 0; k < MS; k++) begin
                        ch_slot[g][k] = '0;
                    end
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Frame layout
    // ----------------------------------------------------------------
    logic [LW-1:0] lane_d [NL];
    logic [jslm_pkg::M1_OFF-1:0] grp;

    // Octet 0 sits in the top byte of each lane word, MSB first
    always_comb begin
        grp = '0;
        for (int i = 0; i < NL; i++) begin
            lane_d[i] = '0;
        end
        case (mode_q)
            jslm_pkg::MODE_9B_WIDE: begin
                for (int c = 0; c < NC; c++) begin
                    for (int h = 0; h < 2; h++) begin
                        for (int k = 0; k < jslm_pkg::M0_FIELDS; k++) begin
                            lane_d[2*c+h][LW-1-jslm_pkg::FIELD_W*k -:
                                jslm_pkg::FIELD_W] =
                                {ch_slot[c][2*k+h], PAD};
                        end
                    end
                end
            end
            jslm_pkg::MODE_9B_PACKED: begin
                // Each channel pair spans three lanes; samples straddle them
                for (int p = 0; p < NC/2; p++) begin
                    grp = {ch_slot[2*p][0],   PAD, ch_slot[2*p][1],   PAD,
                           ch_slot[2*p+1][0], PAD, ch_slot[2*p+1][1], PAD};
                    for (int j = 0; j < jslm_pkg::M1_GROUP; j++) begin
                        lane_d[jslm_pkg::M1_GROUP*p+j]
                            [LW-1 -: jslm_pkg::M1_LANE_W] =
                            grp[jslm_pkg::M1_OFF-1-jslm_pkg::M1_LANE_W*j -:
                                jslm_pkg::M1_LANE_W];
                    end
                end
            end
            jslm_pkg::MODE_8B_SINGLE: begin
                for (int c = 0; c < NC; c++) begin
                    lane_d[c][LW-1 -: jslm_pkg::OCT_W] =
                        ch_slot[c][0][SW-1 -: jslm_pkg::OCT_W];
                end
            end
            default: begin
                for (int c = 0; c < NC; c++) begin
                    for (int k = 0; k < int'(jslm_pkg::NEED_M3); k++) begin
                        lane_d[c][LW-1-jslm_pkg::FIELD10_W*k -:
                            jslm_pkg::FIELD10_W] =
                            {ch_slot[c][k], 1'b0};
                    end
                end
            end
        endcase
        for (int i = 0; i < NL; i++) begin
            if (!en_mask[i]) begin
                lane_d[i] = '0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Output registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            frame_valid <= 1'b0;
            lane_en     <= '0;
            lane_octets <= '0;
            for (int i = 0; i < NL; i++) begin
                lane_data[i] <= '0;
            end
        end else if (ce) begin
            frame_valid <= ch_done[0] && !flush;
            lane_en     <= en_mask;
            lane_octets <= octets;
            if (ch_done[0] && !flush) begin
                lane_data <= lane_d;
            end
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence gathered_s;
        ce && ch_done[0] && !flush;
    endsequence
    sequence framed_s;
        frame_valid ##0 lane_octets == octets;
    endsequence

    frame_follows_a: assert property (gathered_s |=> framed_s)
        else $error("frame not issued after gather");
    wide_lanes_a: assert property ((frame_valid && mode_q == 2'h0)
        |-> $countones(lane_en) == 2 * NUM_CH)
        else $error("mode 0 lane count wrong");
    wide_even_a: assert property ((ce && ch_done[0] && !flush
        && mode_q == 2'h0) |=> lane_data[0][63:55] == $past(ch_slot[0][0])
        && lane_data[1][63:55] == $past(ch_slot[0][1]))
        else $error("mode 0 even/odd split wrong");
    packed_split_a: assert property ((ce && ch_done[0] && !flush
        && mode_q == 2'h1) |=> lane_data[0][51:48] == $past(ch_slot[0][1][8:5])
        && lane_data[1][63:59] == $past(ch_slot[0][1][4:0]))
        else $error("mode 1 sample split wrong");
    packed_single_a: assert property ((frame_valid && mode_q == 2'h1
        && NUM_CH == 1) |-> lane_data[1][55:48] == 8'h00)
        else $error("mode 1 single B slot not zero");
    byte_lane_a: assert property ((ce && ch_done[0] && !flush
        && mode_q == 2'h2) |=> lane_data[0][63:56] == $past(ch_slot[0][0][8:1])
        && lane_data[0][55:0] == '0)
        else $error("mode 2 byte lane wrong");
    byte_count_a: assert property ((frame_valid && mode_q == 2'h2)
        |-> lane_en == NL'((9'h001 << NUM_CH) - 9'h001))
        else $error("mode 2 lane enables wrong");
    quad_field_a: assert property ((ce && ch_done[0] && !flush
        && mode_q == 2'h3) |=> lane_data[0][44] == 1'b0
        && lane_data[0][53:45] == $past(ch_slot[0][1]))
        else $error("mode 3 field wrong");
    tail_zero_a: assert property ((frame_valid && mode_q == 2'h0)
        |-> lane_data[0][3:0] == 4'h0 && lane_data[0][54:52] == 3'h0)
        else $error("mode 0 tail not zero");
    idle_lane_a: assert property (frame_valid
        |-> lane_data[NL-1] == '0 || lane_en[NL-1])
        else $error("idle lane carries data");
endmodule

// *** src/jslm_pkg.sv ***
// Shared constants for the sample lane mapper: widths, link modes,
// per-mode frame shapes and per-variant lane counts.
// Assumes one frame clock and samples presented MSB-aligned, 9 bits wide.
package jslm_pkg;
    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int SAMP_W    = 9;   // Converter sample width
    localparam int OCT_W     = 8;   // One octet
    localparam int CHANS     = 4;   // Channels A to D
    localparam int LANES     = 8;   // Serial lanes of the quad part
    localparam int LANE_W    = 64;  // Widest lane frame, 8 octets
    localparam int MAX_SAMP  = 10;  // Most samples per channel per frame
    localparam int PAD_W     = 3;   // Zero pad after a 9-bit sample
    localparam int FIELD_W   = SAMP_W + PAD_W; // 12-bit field
    localparam int FIELD10_W = SAMP_W + 1;     // 10-bit field
    localparam int TAIL_W    = 4;   // Closing tail nibble of mode 0
    localparam int M0_FIELDS = 5;   // Fields per lane in mode 0
    localparam int M1_OFF    = 48;  // Lane-group span in mode 1, bits
    localparam int M1_LANE_W = 16;  // Two octets per lane in mode 1

    // ----------------------------------------------------------------
    // Link modes
    // ----------------------------------------------------------------
    localparam logic [1:0] MODE_9B_WIDE   = 2'h0; // 9-bit, 8/4/2 lanes
    localparam logic [1:0] MODE_9B_PACKED = 2'h1; // 9-bit, 6/3/2 lanes
    localparam logic [1:0] MODE_8B_SINGLE = 2'h2; // 8-bit, 4/2/1 lanes
    localparam logic [1:0] MODE_9B_QUAD   = 2'h3; // 9-bit, 4 per lane

    // Samples per channel per frame, by mode
    localparam logic [3:0] NEED_M0 = 4'ha;
    localparam logic [3:0] NEED_M1 = 4'h2;
    localparam logic [3:0] NEED_M2 = 4'h1;
    localparam logic [3:0] NEED_M3 = 4'h4;

    // Octets per lane frame, by mode
    localparam logic [3:0] OCT_M0 = 4'h8;
    localparam logic [3:0] OCT_M1 = 4'h2;
    localparam logic [3:0] OCT_M2 = 4'h1;
    localparam logic [3:0] OCT_M3 = 4'h5;

    // Mode 1 lane counts per variant
    localparam logic [3:0] M1_LANES_1CH = 4'h2;
    localparam logic [3:0] M1_LANES_2CH = 4'h3;
    localparam logic [3:0] M1_LANES_4CH = 4'h6;
    localparam int         M1_GROUP     = 3;    // Lanes per channel pair
endpackage

// *** src/jslm_chan_gather.sv ***
// Collects consecutive samples of one channel into a frame's worth of slots.
// Assumes the caller holds need steady except across a flush.
`timescale 1ns/100ps
module jslm_chan_gather #(
    parameter int SW    = jslm_pkg::SAMP_W,
    parameter int DEPTH = jslm_pkg::MAX_SAMP
) (
    // Clock, reset, enable
    input  wire logic          clk,
    input  wire logic          reset,
    input  wire logic          ce,
    // Control
    input  wire logic          flush,
    input  wire logic [3:0]    need,
    // Sample stream
    input  wire logic          in_valid,
    input  wire logic [SW-1:0] in_sample,
    // Gathered frame
    output logic      [SW-1:0] slots [DEPTH],
    output logic               done
);
    logic [SW-1:0] slots_d [DEPTH];
    logic [3:0]    cnt_q;
    logic [3:0]    cnt_d;
    logic          done_d;

    // ----------------------------------------------------------------
    // Slot fill
    // ----------------------------------------------------------------
    // Sample k of the frame lands in slot k, so slot order is time order
    always_comb begin
        slots_d = slots;
        cnt_d   = cnt_q;
        done_d  = 1'b0;
        if (flush) begin
            cnt_d = 4'h0;
        end else if (in_valid) begin
            slots_d[cnt_q] = in_sample;
            if (cnt_q == need - 4'h1) begin
                cnt_d  = 4'h0;
                done_d = 1'b1;
            end else begin
                cnt_d = cnt_q + 4'h1;
            end
        end
    end

    // Slots clear to zero on reset; done gates every use of them
    always_ff @(posedge clk) begin
        if (reset) begin
            cnt_q <= 4'h0;
            done  <= 1'b0;
            for (int i = 0; i < DEPTH; i++) begin
                slots[i] <= '0;
            end
        end else if (ce) begin
            cnt_q <= cnt_d;
            done  <= done_d;
            slots <= slots_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // A completed frame always restarts the count
    gather_wrap_a: assert property ((ce && $past(ce) && done) |-> cnt_q == 4'h0
                                    || $past(flush) == 1'b0 && cnt_q == 4'h0)
        else $error("gather count not restarted after frame");
endmodule

// *** dv/jslm_rx_model.sv ***
// Link receiver model for the sample lane mapper: counts frames and
// reads the first field of lane 0 most significant bit first.
// Assumes frame_valid is a one-cycle pulse on the frame clock.
`timescale 1ns/100ps
module jslm_rx_model (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // Lane frames from the mapper
    input  wire logic        frame_valid,
    input  wire logic [63:0] lane_data [8],
    // Observations
    output logic      [15:0] frames_seen,
    output logic      [8:0]  first_field
);
    // Capture on each frame pulse; a stuck pulse counts once per cycle it is high, on purpose
    always_ff @(posedge clk) begin
        if (reset) begin
            frames_seen <= 16'h0;
            first_field <= 9'h0;
        end else if (frame_valid) begin
            frames_seen <= frames_seen + 16'h1;
            first_field <= lane_data[0][63:55];
        end
    end
endmodule

// *** dv/jslm_mapper_test.sv ***
// Self-checking bench for the quad and single-channel variants of the sample lane mapper.
// Assumes the receiver model sits on the lane outputs.
`timescale 1ns/100ps
module jslm_mapper_test;
    logic        clk;
    logic        reset;
    logic        ce;
    logic [1:0]  link_mode_select;
    logic        samp_valid;
    logic [8:0]  samp [4];
    logic        frame_valid;
    logic [7:0]  lane_en;
    logic [3:0]  lane_octets;
    logic [63:0] lane_data [8];
    logic        one_frame_valid;
    logic [7:0]  one_lane_en;
    logic [3:0]  one_lane_octets;
    logic [63:0] one_lane_data [8];
    logic [15:0] frames_seen;
    logic [8:0]  first_field;
    logic [8:0]  smp [4][10];
    logic [63:0] exp_w [8];
    logic [7:0]  exp_en;
    logic [3:0]  exp_oct;
    int          num_errors = 0;
    int          num_checks = 0;

    jslm_mapper #(.NUM_CH(4)) u_jslm_mapper (
        .clk(clk), .reset(reset), .ce(ce),
        .link_mode_select(link_mode_select), .samp_valid(samp_valid),
        .samp(samp), .frame_valid(frame_valid), .lane_en(lane_en),
        .lane_octets(lane_octets), .lane_data(lane_data));

    // Single-channel variant on the same stream: only its lanes carry data
    jslm_mapper #(.NUM_CH(1)) u_jslm_mapper_one (
        .clk(clk), .reset(reset), .ce(ce),
        .link_mode_select(link_mode_select), .samp_valid(samp_valid),
        .samp(samp), .frame_valid(one_frame_valid), .lane_en(one_lane_en),
        .lane_octets(one_lane_octets), .lane_data(one_lane_data));

    jslm_rx_model u_jslm_rx_model (
        .clk(clk), .reset(reset), .frame_valid(frame_valid),
        .lane_data(lane_data), .frames_seen(frames_seen),
        .first_field(first_field));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic cmp(string what, logic [63:0] e, logic [63:0] g);
        num_checks++;
        if (e !== g) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask

    // Distinct values so a swapped or shifted field shows up
    task automatic fill(int base);
        for (int c = 0; c < 4; c++)
            for (int k = 0; k < 10; k++)
                smp[c][k] = 9'(base + c * 71 + k * 29);
    endtask

    task automatic send(int n);
        for (int k = 0; k < n; k++) begin
            @(posedge clk);
            samp_valid <= 1'b1;
            for (int c = 0; c < 4; c++)
                samp[c] <= smp[c][k];
        end
        @(posedge clk);
        samp_valid <= 1'b0;
    endtask

    // Mode change flushes, so let a few edges pass before samples
    task automatic set_mode(logic [1:0] m);
        @(posedge clk);
        link_mode_select <= m;
        repeat (3) @(posedge clk);
    endtask

    // Expected lane words, left-justified, zero tails
    task automatic calc_exp(logic [1:0] m);
        logic [47:0] g;
        for (int l = 0; l < 8; l++)
            exp_w[l] = 64'h0;
        case (m)
            2'h0: begin
                for (int c = 0; c < 4; c++)
                    for (int k = 0; k < 5; k++) begin
                        exp_w[2*c][63-12*k -: 12]   = {smp[c][2*k], 3'h0};
                        exp_w[2*c+1][63-12*k -: 12] = {smp[c][2*k+1], 3'h0};
                    end
                exp_en  = 8'hff;
                exp_oct = 4'h8;
            end
            2'h1: begin
                for (int p = 0; p < 2; p++) begin
                    g = {smp[2*p][0], 3'h0, smp[2*p][1], 3'h0,
                         smp[2*p+1][0], 3'h0, smp[2*p+1][1], 3'h0};
                    for (int j = 0; j < 3; j++)
                        exp_w[3*p+j][63 -: 16] = g[47-16*j -: 16];
                end
                exp_en  = 8'h3f;
                exp_oct = 4'h2;
            end
            2'h2: begin
                for (int c = 0; c < 4; c++)
                    exp_w[c][63 -: 8] = smp[c][0][8:1];
                exp_en  = 8'h0f;
                exp_oct = 4'h1;
            end
            default: begin
                for (int c = 0; c < 4; c++)
                    for (int k = 0; k < 4; k++)
                        exp_w[c][63-10*k -: 10] = {smp[c][k], 1'b0};
                exp_en  = 8'h0f;
                exp_oct = 4'h5;
            end
        endcase
    endtask

    // Bounded wait for the frame pulse, then judge every lane of both
    // variants; the single one has no channel B, so its slots read zero
    task automatic expect_frame(logic [1:0] m);
        int          n;
        logic [7:0]  one_en;
        logic [63:0] w;
        n = 0;
        calc_exp(m);
        one_en = m[1] ? 8'h01 : 8'h03;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (frame_valid !== 1'b1 && n < 30);
        if (n >= 30) begin
            num_errors++;
            $display("MISMATCH frame_valid expected 1 seen timeout");
            finish_test();
        end
        for (int l = 0; l < 8; l++) begin
            cmp($sformatf("lane %0d", l), exp_w[l], lane_data[l]);
            w = one_en[l] ? exp_w[l] : 64'h0;
            if (m == 2'h1 && l == 1)
                w[55:48] = 8'h00;
            cmp($sformatf("one lane %0d", l), w, one_lane_data[l]);
        end
        cmp("lane_en", 64'(exp_en), 64'(lane_en));
        cmp("lane_octets", 64'(exp_oct), 64'(lane_octets));
        cmp("one frame_valid", 64'h1, 64'(one_frame_valid));
        cmp("one lane_en", 64'(one_en), 64'(one_lane_en));
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic chk_reset();
        cmp("reset frame_valid", 64'h0, 64'(frame_valid));
        cmp("reset lane_en", 64'h0, 64'(lane_en));
        cmp("reset lane_data[7]", 64'h0, lane_data[7]);
    endtask

    task automatic run_mode(logic [1:0] m, int n, int base);
        set_mode(m);
        fill(base);
        send(n);
        expect_frame(m);
    endtask

    // Partial frame dropped by a mode change, stale samples held off by ce
    task automatic flush_drop();
        set_mode(2'h3);
        fill(64);
        send(2);
        @(posedge clk);
        link_mode_select <= 2'h2;
        samp_valid       <= 1'b1;
        @(posedge clk);
        link_mode_select <= 2'h3;
        samp_valid       <= 1'b0;
        repeat (3) @(posedge clk);
        ce <= 1'b0;
        send(4);
        @(posedge clk);
        ce <= 1'b1;
        fill(300);
        send(4);
        expect_frame(2'h3);
    endtask

    // ------------------------------------------------------------
    // Clock and main sequence
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial begin
        reset            = 1'b1;
        ce               = 1'b1;
        link_mode_select = 2'h0;
        samp_valid       = 1'b0;
        for (int c = 0; c < 4; c++)
            samp[c] = 9'h0;
        repeat (5) @(posedge clk);
        #1;
        chk_reset();
        @(posedge clk);
        reset <= 1'b0;
        run_mode(2'h0, 10, 5);
        run_mode(2'h1, 2, 400);
        run_mode(2'h2, 1, 257);
        run_mode(2'h3, 4, 33);
        flush_drop();
        @(posedge clk);
        #1;
        cmp("frames_seen", 64'h5, 64'(frames_seen));
        cmp("first_field", 64'(smp[0][0]), 64'(first_field));
        finish_test();
    end
endmodule
